// file: design/port_b_upper_pin_functions.v
// pin function multiplexer for port b bits 28 down to 24
`timescale 1ns/10ps
`default_nettype none
`include "port_b_upper_defs.vh"

module port_b_upper_pin_functions (
    input  wire        clk_in,                    // 50 MHz clock
    input  wire        rstn_in,                   // synchronous reset, active low
    input  wire [14:0] fn_sel_in,                 // 3-bit function select per pin
    input  wire [28:24] port_b_pin_in,            // pin levels seen at the pads
    output reg  [28:24] port_b_pin_out,           // pin drive values
    output reg  [28:24] port_b_pin_oe_out,        // high while the pin is driven
    input  wire [28:24] gpio_data_in,             // software output values
    input  wire [28:24] gpio_dir_in,              // software direction, 1 = output
    output reg  [28:24] gpio_data_out,            // filtered pin levels for software
    input  wire        fast_comm_rts_n_in,        // fast controller request, active low
    output reg         fast_comm_rx_er_out,       // phy receive error
    output reg         fast_comm_col_out,         // phy collision
    output reg         fast_comm_crs_out,         // phy carrier sense
    input  wire [3:0]  fast_comm_txd_in,          // fast controller transmit nibble
    output reg         port_b_bit_22_txd0_out,    // nibble lsb towards the bit-22 pin
    input  wire        serial_comm_rts_n_in,      // serial controller request, active low
    input  wire        ether_transmit_enable_in,  // serial controller transmit enable
    input  wire        serial_comm_ether_mode_in, // serial controller in ethernet mode
    output reg         tdm_b2_tx_sync_out,        // channel b2 transmit sync
    input  wire        tdm_serial_tx_data_in,     // channel c2 serial transmit bit
    output reg         tdm_c2_tx_sync_out,        // channel c2 transmit sync
    output reg         tdm_c2_rx_sync_out,        // channel c2 receive sync
    input  wire        tdm_nibble_tx_msb_in,      // channel a1 transmit nibble msb
    output reg         tdm_nibble_rx_msb_out,     // channel a1 receive nibble msb
    input  wire        tdm_rx_sample_in,          // strobe: take one c2 receive bit
    output reg         tdm_rx_room_out,           // buffer can take a bit
    output reg         tdm_serial_rx_data_out,    // head of receive buffer
    output reg         tdm_serial_rx_valid_out,   // head holds a bit
    input  wire        tdm_serial_rx_ready_in     // consumer takes the head bit
);

    // ==========================================================
    // select decode
    wire [2:0] sel_28 = fn_sel_in[`SEL_POS_28 +: `SEL_W];
    wire [2:0] sel_27 = fn_sel_in[`SEL_POS_27 +: `SEL_W];
    wire [2:0] sel_26 = fn_sel_in[`SEL_POS_26 +: `SEL_W];
    wire [2:0] sel_25 = fn_sel_in[`SEL_POS_25 +: `SEL_W];
    wire [2:0] sel_24 = fn_sel_in[`SEL_POS_24 +: `SEL_W];

    // ==========================================================
    // input synchronisers, one per pin
    reg  [28:24] sync1_q;
    reg  [28:24] sync2_q;
    reg  [28:24] sync3_q;
    reg  [28:24] level_q;

    genvar g;
    generate
        for (g = 24; g <= 28; g = g + 1) begin : pin_sync
            // three stages; the level moves once stages two and three agree
            always @(posedge clk_in) begin
                if (!rstn_in) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    level_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= port_b_pin_in[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        level_q[g] <= sync3_q[g];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // pin drive and direction
    reg  [28:24] pin_d;
    reg  [28:24] oe_d;

    // each pin follows exactly one selected function
    always @* begin
        pin_d = gpio_data_in;                            // RQ17
        oe_d  = gpio_dir_in;                             // RQ17
        case (sel_28)
            `FN28_RTS: begin
                pin_d[28] = fast_comm_rts_n_in;          // RQ1 RQ2
                oe_d[28]  = 1'b1;
            end
            `FN28_SERIAL: begin
                if (serial_comm_ether_mode_in) begin
                    pin_d[28] = ether_transmit_enable_in; // RQ4
                end else begin
                    pin_d[28] = serial_comm_rts_n_in;    // RQ3
                end
                oe_d[28] = 1'b1;
            end
            `FN28_RX_ER, `FN28_TSYNC: begin
                pin_d[28] = 1'b0;                        // RQ16
                oe_d[28]  = 1'b0;
            end
            default: begin
                pin_d[28] = gpio_data_in[28];
                oe_d[28]  = gpio_dir_in[28];
            end
        endcase
        case (sel_27)
            `FN27_TXD: begin
                pin_d[27] = tdm_serial_tx_data_in;       // RQ11
                oe_d[27]  = 1'b1;
            end
            `FN27_COL: begin
                pin_d[27] = 1'b0;
                oe_d[27]  = 1'b0;
            end
            default: begin
                pin_d[27] = gpio_data_in[27];
                oe_d[27]  = gpio_dir_in[27];
            end
        endcase
        case (sel_26)
            `FN26_CRS, `FN26_RXD: begin
                pin_d[26] = 1'b0;                        // RQ12
                oe_d[26]  = 1'b0;
            end
            default: begin
                pin_d[26] = gpio_data_in[26];
                oe_d[26]  = gpio_dir_in[26];
            end
        endcase
        case (sel_25)
            `FN25_NIB: begin
                pin_d[25] = fast_comm_txd_in[3];         // RQ8
                oe_d[25]  = 1'b1;
            end
            `FN25_A1_TX: begin
                pin_d[25] = tdm_nibble_tx_msb_in;        // RQ9
                oe_d[25]  = 1'b1;
            end
            `FN25_TSYNC: begin
                pin_d[25] = 1'b0;
                oe_d[25]  = 1'b0;
            end
            default: begin
                pin_d[25] = gpio_data_in[25];
                oe_d[25]  = gpio_dir_in[25];
            end
        endcase
        case (sel_24)
            `FN24_NIB: begin
                pin_d[24] = fast_comm_txd_in[2];         // RQ8
                oe_d[24]  = 1'b1;
            end
            `FN24_A1_RX, `FN24_RSYNC: begin
                pin_d[24] = 1'b0;
                oe_d[24]  = 1'b0;
            end
            default: begin
                pin_d[24] = gpio_data_in[24];
                oe_d[24]  = gpio_dir_in[24];
            end
        endcase
    end

    // ==========================================================
    // registered pin outputs and peripheral inputs
    // request lines get no alignment to any data bit clock
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            port_b_pin_out         <= `RST_PINS;
            port_b_pin_oe_out      <= `RST_PINS;
            gpio_data_out          <= `RST_PINS;
            fast_comm_rx_er_out    <= 1'b0;
            fast_comm_col_out      <= 1'b0;
            fast_comm_crs_out      <= 1'b0;
            port_b_bit_22_txd0_out <= 1'b0;
            tdm_b2_tx_sync_out     <= 1'b0;
            tdm_c2_tx_sync_out     <= 1'b0;
            tdm_c2_rx_sync_out     <= 1'b0;
            tdm_nibble_rx_msb_out  <= 1'b0;
        end else begin
            port_b_pin_out         <= pin_d;             // RQ1
            port_b_pin_oe_out      <= oe_d;              // RQ16
            gpio_data_out          <= level_q;           // RQ17
            // unselected functions see a low, inactive input
            fast_comm_rx_er_out    <= (sel_28 == `FN28_RX_ER) & level_q[28]; // RQ5
            fast_comm_col_out      <= (sel_27 == `FN27_COL) & level_q[27];   // RQ6
            fast_comm_crs_out      <= (sel_26 == `FN26_CRS) & level_q[26];   // RQ7
            port_b_bit_22_txd0_out <= (sel_25 == `FN25_NIB) & fast_comm_txd_in[0]; // RQ15
            tdm_b2_tx_sync_out     <= (sel_28 == `FN28_TSYNC) & level_q[28]; // RQ13
            tdm_c2_tx_sync_out     <= (sel_25 == `FN25_TSYNC) & level_q[25]; // RQ13
            tdm_c2_rx_sync_out     <= (sel_24 == `FN24_RSYNC) & level_q[24]; // RQ14
            tdm_nibble_rx_msb_out  <= (sel_24 == `FN24_A1_RX) & level_q[24]; // RQ10
        end
    end

    // ==========================================================
    // two-entry receive buffer for channel c2 serial bits
    reg        head_q;
    reg        tail_q;
    reg  [1:0] cnt_q;
    reg  [1:0] cnt_d;
    wire       rx_sel = (sel_26 == `FN26_RXD);
    wire       push   = tdm_rx_sample_in & rx_sel & tdm_rx_room_out;
    wire       pop    = tdm_serial_rx_valid_out & tdm_serial_rx_ready_in;

    // occupancy after this cycle's push and pop
    always @* begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    // head is the output word; tail waits behind it
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            head_q                  <= 1'b0;
            tail_q                  <= 1'b0;
            cnt_q                   <= `RST_CNT;
            tdm_rx_room_out         <= 1'b1;
            tdm_serial_rx_valid_out <= 1'b0;
            tdm_serial_rx_data_out  <= 1'b0;
        end else begin
            cnt_q                   <= cnt_d;
            tdm_rx_room_out         <= (cnt_d != 2'h2);
            tdm_serial_rx_valid_out <= (cnt_d != 2'h0);
            if (pop) begin
                if (cnt_q == 2'h2) begin
                    head_q                 <= tail_q;
                    tdm_serial_rx_data_out <= tail_q;
                    if (push) begin
                        tail_q <= level_q[26];           // RQ12
                    end
                end else if (push) begin
                    head_q                 <= level_q[26];
                    tdm_serial_rx_data_out <= level_q[26];
                end
            end else if (push) begin
                if (cnt_q == 2'h0) begin
                    head_q                 <= level_q[26]; // RQ12
                    tdm_serial_rx_data_out <= level_q[26];
                end else begin
                    tail_q <= level_q[26];
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: inc/port_b_upper_defs.vh
// constants for the port b bits 28..24 pin function logic
// Contract
// RQ1 - fast controller request-to-send runs independent of transmit data clock edges
// RQ2 - fast controller requests by driving its request line low; grant returns low
// RQ3 - second serial controller requests by driving low; peer accepts by returning low
// RQ4 - in ethernet mode the bit-28 output carries transmit enable instead
// RQ5 - phy reports receive error in through bit 28 in mii mode
// RQ6 - phy reports collision in through bit 27 in mii mode
// RQ7 - phy reports carrier activity in through bit 26 in mii mode
// RQ8 - fast controller drives nibble bit 3 on bit 25, bit 2 on bit 24
// RQ9 - tdm a1 nibble mode drives transmit nibble msb on bit 25
// RQ10 - tdm a1 nibble mode takes receive nibble msb from bit 24
// RQ11 - tdm c2 shifts serial transmit data out on bit 27 as output
// RQ12 - tdm c2 samples serial receive data from bit 26 as input
// RQ13 - highway supplies transmit sync on bit 28 for b2, bit 25 for c2
// RQ14 - highway supplies c2 receive sync on bit 24
// RQ15 - fast controller drives nibble bit 0 on bit 22 in nibble modes
// RQ16 - one function per pin, direction follows it, unselected functions see inactive input
// RQ17 - with no function selected the pin is software-directed general-purpose i/o
`ifndef PORT_B_UPPER_DEFS_VH
`define PORT_B_UPPER_DEFS_VH

// select field width and positions inside fn_sel_in
`define SEL_W        3
`define SEL_POS_24   0
`define SEL_POS_25   3
`define SEL_POS_26   6
`define SEL_POS_27   9
`define SEL_POS_28   12

// common select code
`define FN_GPIO      3'h0
// bit 28 codes
`define FN28_RTS     3'h1
`define FN28_RX_ER   3'h2
`define FN28_SERIAL  3'h3
`define FN28_TSYNC   3'h4
// bit 27 codes
`define FN27_COL     3'h1
`define FN27_TXD     3'h2
// bit 26 codes
`define FN26_CRS     3'h1
`define FN26_RXD     3'h2
// bit 25 codes
`define FN25_NIB     3'h1
`define FN25_A1_TX   3'h2
`define FN25_TSYNC   3'h3
// bit 24 codes
`define FN24_NIB     3'h1
`define FN24_A1_RX   3'h2
`define FN24_RSYNC   3'h3

// reset values
`define RST_PINS     5'h00
`define RST_RTS_N    1'h1
`define RST_CNT      2'h0

`endif

// file: tb/pin_partner.sv
// far-side model: phy and tdm highway driving the pins they own
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    input  wire logic        clk_in,    // board clock
    input  wire logic [14:0] fn_sel_in, // board wiring choice per pin
    input  wire logic [4:0]  level_in,  // levels to present, bit 0 is pin 24
    output logic      [4:0]  pad_out    // drive, or a toggling pattern when released
);
    logic       flip_q = 1'b0;
    logic [4:0] en;
    // released lines toggle so a stale level never looks like data
    always @(posedge clk_in) flip_q <= ~flip_q;
    // the far side owns a pin only where the device takes it as an input
    assign en[4] = fn_sel_in[14:12] == 3'h2 || fn_sel_in[14:12] == 3'h4;
    assign en[3] = fn_sel_in[11:9] == 3'h1;
    assign en[2] = fn_sel_in[8:6] == 3'h1 || fn_sel_in[8:6] == 3'h2;
    assign en[1] = fn_sel_in[5:3] == 3'h3;
    assign en[0] = fn_sel_in[2:0] == 3'h2 || fn_sel_in[2:0] == 3'h3;
    assign pad_out = (en & level_in) | (~en & {5{flip_q}});
endmodule
`default_nettype wire

// file: tb/port_b_upper_sva.sv
// concurrent checks on the port b upper pin function ports
`timescale 1ns/10ps
`default_nettype none
module port_b_upper_sva (
    input wire logic         clk_in, rstn_in, fast_comm_rts_n_in, serial_comm_rts_n_in,
    input wire logic         ether_transmit_enable_in, serial_comm_ether_mode_in,
    input wire logic         tdm_serial_tx_data_in, tdm_rx_sample_in, tdm_serial_rx_ready_in,
    input wire logic         fast_comm_crs_out, port_b_bit_22_txd0_out, tdm_rx_room_out,
    input wire logic         tdm_serial_rx_data_out, tdm_serial_rx_valid_out,
    input wire logic [14:0]  fn_sel_in,
    input wire logic [3:0]   fast_comm_txd_in,
    input wire logic [28:24] port_b_pin_in, port_b_pin_out, port_b_pin_oe_out
);
    logic [1:0] up_q;
    // counts edges since release so registered outputs have settled
    always @(posedge clk_in) up_q <= rstn_in ? {up_q[0], 1'b1} : 2'h0;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ==========================================
    // pin drive
    property p_fast_rts; up_q[1] && fn_sel_in[14:12] == 3'h1 |=>
        port_b_pin_oe_out[28] && port_b_pin_out[28] == $past(fast_comm_rts_n_in); endproperty
    a_fast_rts: assert property (p_fast_rts) else $error("pin 28 fast");
    property p_ser_rts; up_q[1] && fn_sel_in[14:12] == 3'h3 && !serial_comm_ether_mode_in
        |=> port_b_pin_out[28] == $past(serial_comm_rts_n_in); endproperty
    a_ser_rts: assert property (p_ser_rts) else $error("pin 28 serial");
    property p_ether; up_q[1] && fn_sel_in[14:12] == 3'h3 && serial_comm_ether_mode_in
        |=> port_b_pin_out[28] == $past(ether_transmit_enable_in); endproperty
    a_ether: assert property (p_ether) else $error("pin 28 enable");
    property p_nibble; up_q[1] && fn_sel_in[5:0] == 6'h09 |=>
        port_b_pin_out[25:24] == $past(fast_comm_txd_in[3:2]) &&
        port_b_bit_22_txd0_out == $past(fast_comm_txd_in[0]); endproperty
    a_nibble: assert property (p_nibble) else $error("nibble order");
    property p_c2_tx; up_q[1] && fn_sel_in[11:9] == 3'h2 |=>
        port_b_pin_oe_out[27] && port_b_pin_out[27] == $past(tdm_serial_tx_data_in); endproperty
    a_c2_tx: assert property (p_c2_tx) else $error("pin 27 serial");
    property p_in_dir; fn_sel_in[8:6] == 3'h2 ##1 fn_sel_in[8:6] == 3'h2
        |-> !port_b_pin_oe_out[26]; endproperty
    a_in_dir: assert property (p_in_dir) else $error("pin 26 driven");
    // ==========================================
    // pin sense and receive buffer
    property p_crs; (up_q[1] && fn_sel_in[8:6] == 3'h1 && port_b_pin_in[26]) [*7]
        |-> fast_comm_crs_out; endproperty
    a_crs: assert property (p_crs) else $error("carrier lost");
    property p_hold; tdm_serial_rx_valid_out && !tdm_serial_rx_ready_in
        |=> tdm_serial_rx_valid_out && $stable(tdm_serial_rx_data_out); endproperty
    a_hold: assert property (p_hold) else $error("head dropped");
    property p_push; tdm_rx_sample_in && fn_sel_in[8:6] == 3'h2 && tdm_rx_room_out &&
        !tdm_serial_rx_valid_out |=> tdm_serial_rx_valid_out; endproperty
    a_push: assert property (p_push) else $error("push lost");
    cover property (fn_sel_in[14:12] == 3'h3 && serial_comm_ether_mode_in);
    cover property (!tdm_rx_room_out);
    cover property (tdm_serial_rx_valid_out && tdm_serial_rx_ready_in);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the port b upper pin function block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [14:0] sel;
        logic [5:0]  ctl;  // fast rts_n, serial rts_n, enable, ether mode, c2 tx, a1 msb
        logic [3:0]  txd;
        logic [4:0]  gd, gdir, xo, xoe;
        logic        x22;
    } row_t;
    row_t         rows [0:5];
    logic         clk_in, rstn_in, fast_comm_rts_n_in, serial_comm_rts_n_in;
    logic         ether_transmit_enable_in, serial_comm_ether_mode_in, tdm_serial_tx_data_in;
    logic         tdm_nibble_tx_msb_in, tdm_rx_sample_in, tdm_serial_rx_ready_in;
    logic [14:0]  fn_sel_in;
    logic [3:0]   fast_comm_txd_in;
    logic [28:24] gpio_data_in, gpio_dir_in;
    logic [4:0]   lvl;
    wire  [4:0]   ppad;
    wire  [28:24] port_b_pin_in, port_b_pin_out, port_b_pin_oe_out, gpio_data_out;
    wire          fast_comm_rx_er_out, fast_comm_col_out, fast_comm_crs_out;
    wire          port_b_bit_22_txd0_out, tdm_b2_tx_sync_out, tdm_c2_tx_sync_out;
    wire          tdm_c2_rx_sync_out, tdm_nibble_rx_msb_out, tdm_rx_room_out;
    wire          tdm_serial_rx_data_out, tdm_serial_rx_valid_out;
    int           fail_count, check_count, cycles;
    port_b_upper_pin_functions dut (.clk_in, .rstn_in, .fn_sel_in, .port_b_pin_in,
        .port_b_pin_out, .port_b_pin_oe_out, .gpio_data_in, .gpio_dir_in, .gpio_data_out,
        .fast_comm_rts_n_in, .fast_comm_rx_er_out, .fast_comm_col_out, .fast_comm_crs_out,
        .fast_comm_txd_in, .port_b_bit_22_txd0_out, .serial_comm_rts_n_in,
        .ether_transmit_enable_in, .serial_comm_ether_mode_in, .tdm_b2_tx_sync_out,
        .tdm_serial_tx_data_in, .tdm_c2_tx_sync_out, .tdm_c2_rx_sync_out, .tdm_nibble_tx_msb_in,
        .tdm_nibble_rx_msb_out, .tdm_rx_sample_in, .tdm_rx_room_out, .tdm_serial_rx_data_out,
        .tdm_serial_rx_valid_out, .tdm_serial_rx_ready_in);
    pin_partner far (.clk_in, .fn_sel_in, .level_in(lvl), .pad_out(ppad));
    // pad level: the device where it drives, else the far side
    assign port_b_pin_in = (port_b_pin_oe_out & port_b_pin_out) | (~port_b_pin_oe_out & ppad);
    // ==========================================
    // helpers
    task chk(input logic [7:0] exp, got, input string nm);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task push(input logic b);
        @(posedge clk_in);
        lvl[2] <= b;
        wt(7);
        @(posedge clk_in);
        tdm_rx_sample_in <= 1'b1;
        @(posedge clk_in);
        tdm_rx_sample_in <= 1'b0;
        #1;
    endtask
    task pop(input logic b);
        chk({6'h00, 1'b1, b}, {6'h00, tdm_serial_rx_valid_out, tdm_serial_rx_data_out}, "head");
        @(posedge clk_in);
        tdm_serial_rx_ready_in <= 1'b1;
        @(posedge clk_in);
        tdm_serial_rx_ready_in <= 1'b0;
        #1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            complete_run;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {rstn_in, tdm_rx_sample_in, tdm_serial_rx_ready_in, fn_sel_in, lvl} = '0;
        {fast_comm_rts_n_in, serial_comm_rts_n_in, ether_transmit_enable_in} = 3'h6;
        {serial_comm_ether_mode_in, tdm_serial_tx_data_in, tdm_nibble_tx_msb_in} = 3'h0;
        {fast_comm_txd_in, gpio_data_in, gpio_dir_in} = '0;
        {fail_count, check_count, cycles} = '0;
        rows[0] = '{15'h0000, 6'h30, 4'h0, 5'h15, 5'h1F, 5'h15, 5'h1F, 1'h0};
        rows[1] = '{15'h1409, 6'h12, 4'h9, 5'h00, 5'h00, 5'h0A, 5'h1B, 1'h1};
        rows[2] = '{15'h3010, 6'h29, 4'h0, 5'h08, 5'h08, 5'h0A, 5'h1A, 1'h0};
        rows[3] = '{15'h3010, 6'h2C, 4'h0, 5'h08, 5'h08, 5'h18, 5'h1A, 1'h0};
        rows[4] = '{15'h1409, 6'h30, 4'h6, 5'h00, 5'h00, 5'h11, 5'h1B, 1'h0};
        rows[5] = '{15'h225B, 6'h30, 4'hF, 5'h1F, 5'h1F, 5'h00, 5'h00, 1'h0};
        wt(8);
        chk(8'h02, {3'h0, port_b_pin_oe_out, tdm_rx_room_out, tdm_serial_rx_valid_out}, "rst");
        @(posedge clk_in);
        rstn_in <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk_in);
            {fn_sel_in, fast_comm_rts_n_in, serial_comm_rts_n_in, ether_transmit_enable_in,
                serial_comm_ether_mode_in, tdm_serial_tx_data_in, tdm_nibble_tx_msb_in,
                fast_comm_txd_in, gpio_data_in, gpio_dir_in} <= rows[i][45:11];
            wt(2);
            chk({3'h0, rows[i].xo}, {3'h0, port_b_pin_out & rows[i].xoe}, "out");
            chk({3'h0, rows[i].xoe}, {3'h0, port_b_pin_oe_out}, "oe");
            chk({7'h00, rows[i].x22}, {7'h00, port_b_bit_22_txd0_out}, "bit22");
        end
        // far side drives every input-selected pin high
        @(posedge clk_in);
        lvl <= 5'h1F;
        wt(8);
        chk(8'h1F, {3'h0, fast_comm_rx_er_out, fast_comm_col_out, fast_comm_crs_out,
            tdm_c2_tx_sync_out, tdm_c2_rx_sync_out}, "sense");
        chk(8'h00, {6'h00, tdm_b2_tx_sync_out, tdm_nibble_rx_msb_out}, "unsel");
        chk(8'h1F, {3'h0, gpio_data_out}, "gpio in");
        @(posedge clk_in);
        fn_sel_in <= 15'h4082;
        wt(8);
        chk(8'h03, {6'h00, tdm_b2_tx_sync_out, tdm_nibble_rx_msb_out}, "b2 a1");
        chk(8'h00, {5'h00, fast_comm_rx_er_out, fast_comm_col_out, fast_comm_crs_out}, "off");
        // fill the buffer past full while the consumer stalls, then drain
        push(1'b1);
        push(1'b0);
        chk(8'h00, {7'h00, tdm_rx_room_out}, "room");
        push(1'b1);
        pop(1'b1);
        pop(1'b0);
        chk(8'h00, {7'h00, tdm_serial_rx_valid_out}, "empty");
        complete_run;
    end
endmodule
bind port_b_upper_pin_functions port_b_upper_sva chk_i (.clk_in, .rstn_in,
    .fast_comm_rts_n_in, .serial_comm_rts_n_in, .ether_transmit_enable_in,
    .serial_comm_ether_mode_in, .tdm_serial_tx_data_in, .tdm_rx_sample_in,
    .tdm_serial_rx_ready_in, .fast_comm_crs_out, .port_b_bit_22_txd0_out, .tdm_rx_room_out,
    .tdm_serial_rx_data_out, .tdm_serial_rx_valid_out, .fn_sel_in, .fast_comm_txd_in,
    .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe_out);
`default_nettype wire
